/* File: rtl/cpac_aux_div.v */
`timescale 1ns/10ps
`include "cpac_map.vh"

// Produces a one-cycle tick at the reference rate divided by 1, 4, 16 or 32.
module cpac_aux_div (
    input wire ref_clk,
    input wire rst,
    input wire [1:0] divSel,
    output wire auxTick
);

    reg [4:0] divCnt_r;
    reg [4:0] divCnt_nxt;
    reg [4:0] term;

    always @* begin
        case (divSel)
            2'h0: term = `CPAC_DIV0_TERM;
            2'h1: term = `CPAC_DIV1_TERM;
            2'h2: term = `CPAC_DIV2_TERM;
            default: term = `CPAC_DIV3_TERM;
        endcase
    end

    // A lowered ratio while the count is above it restarts the count at once.
    assign auxTick = (divCnt_r >= term);

    always @* begin
        if (auxTick) begin
            divCnt_nxt = 5'h00;
        end else begin
            divCnt_nxt = divCnt_r + 5'h01;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            divCnt_r <= 5'h00;
        end else begin
            divCnt_r <= divCnt_nxt;
        end
    end

endmodule // cpac_aux_div

/* File: rtl/cpac_config_regs.v */
`timescale 1ns/10ps
`include "cpac_map.vh"

// Behaviour
// - Sink current code, bits 6:0, 20 uA steps.
// - Source current code, bits 13:7, reset 100.
// - Offset current code, bits 20:14, 5 uA.
// - Bit 23 selects high current pump mode.
// - Charge pump register resets to 0x403264.
// - Measurement lasts two to the code reference divider pulses.
// - Force bit applies stored capacitor selection.
// - Bypass bit skips oscillator autocalibration.
// - Block bit suppresses internal oscillator transfers.
// - Clock select divides reference by 1/4/16/32.
// - Calibration register resets 0x002205; host programs 0x002047.
module cpac_config_regs #(
    parameter ADDR_W = 6,
    parameter CAPS_W = 8,
    parameter LINK_W = 16
) (
    input wire ref_clk,
    input wire rst,
    input wire wrEn,
    input wire [ADDR_W-1:0] wrAddr,
    input wire [23:0] wrData,
    input wire rdEn,
    input wire [ADDR_W-1:0] rdAddr,
    output reg [23:0] rdData,
    output reg rdValid,
    output wire [6:0] pumpSinkCurrentCode,
    output wire [6:0] pumpSourceCurrentCode,
    output wire [6:0] pumpOffsetCurrentCode,
    output wire offsetSourceEnable,
    output wire offsetSinkEnable,
    output wire highCurrentPumpSelect,
    output reg [11:0] sinkCurrentUa,
    output reg [11:0] sourceCurrentUa,
    output reg [11:0] offsetCurrentUa,
    output wire [2:0] tuneMeasureLength,
    output wire forceStoredCaps,
    output wire calibrationBypass,
    output wire oscillatorLinkBlock,
    output wire [1:0] auxClkSelect,
    input wire calRequest,
    input wire refDivTick,
    input wire [CAPS_W-1:0] measuredCaps,
    input wire [CAPS_W-1:0] storedCaps,
    output reg [CAPS_W-1:0] capSelect,
    output wire calBusy,
    output reg calDone,
    input wire oscRegWrite,
    input wire [LINK_W-1:0] oscRegData,
    output reg linkClk,
    output reg linkData,
    output reg linkFrame,
    output wire linkBusy
);

    localparam CAL_IDLE = 2'h0;
    localparam CAL_SYNC = 2'h1;
    localparam CAL_MEASURE = 2'h2;
    localparam CAL_FINISH = 2'h3;

    reg [23:0] pumpReg_r;
    reg [23:0] calReg_r;
    reg [1:0] calState_r;
    reg [1:0] calState_nxt;
    reg [8:0] measCnt_r;
    reg [8:0] measCnt_nxt;
    reg [CAPS_W-1:0] calCaps_r;
    reg [LINK_W-1:0] linkShift_r;
    reg [7:0] linkBits_r;
    reg linkActive_r;
    wire auxTick;
    wire [8:0] measTarget;
    wire linkStart;
    wire pumpWrite;
    wire calWrite;

    // Scales a 7-bit current code by its step size in microamps.
    function [11:0] codeToUa;
        input [6:0] code;
        input [11:0] step;
        reg [18:0] prod;
        begin
            prod = {12'h000, code} * {7'h00, step};
            codeToUa = prod[11:0];
        end
    endfunction

    // True when a register index selects the given mapped register.
    function hitsReg;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] index;
        begin
            hitsReg = (addr == index);
        end
    endfunction

    // Selects the stored word for a register index, zero when unmapped.
    function [23:0] readMux;
        input [ADDR_W-1:0] addr;
        input [23:0] pumpWord;
        input [23:0] calWord;
        begin
            if (hitsReg(addr, `CPAC_ADDR_PUMP)) begin
                readMux = pumpWord;
            end else if (hitsReg(addr, `CPAC_ADDR_CAL)) begin
                readMux = calWord;
            end else begin
                readMux = 24'h000000;
            end
        end
    endfunction

    // Write strobes per register; a write to any other index is ignored.
    assign pumpWrite = wrEn && hitsReg(wrAddr, `CPAC_ADDR_PUMP);
    assign calWrite = wrEn && hitsReg(wrAddr, `CPAC_ADDR_CAL);

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pumpReg_r <= `CPAC_RST_PUMP;
        end else if (pumpWrite) begin
            pumpReg_r <= wrData;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            calReg_r <= `CPAC_RST_CAL;
        end else if (calWrite) begin
            calReg_r <= wrData;
        end
    end

    // A read in the same cycle as a write returns the old word.
    // The read word is registered so that it lines up with rdValid.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData <= 24'h000000;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdEn;
            if (rdEn) begin
                rdData <= readMux(rdAddr, pumpReg_r, calReg_r);
            end
        end
    end

    // Field outputs are plain slices, so a write shows on them the next cycle.
    assign pumpSinkCurrentCode = pumpReg_r[`CPAC_PUMP_SINK_MSB:`CPAC_PUMP_SINK_LSB];
    assign pumpSourceCurrentCode = pumpReg_r[`CPAC_PUMP_SOURCE_MSB:`CPAC_PUMP_SOURCE_LSB];
    assign pumpOffsetCurrentCode = pumpReg_r[`CPAC_PUMP_OFFSET_MSB:`CPAC_PUMP_OFFSET_LSB];
    assign offsetSourceEnable = pumpReg_r[`CPAC_PUMP_OFS_SRC_BIT];
    assign offsetSinkEnable = pumpReg_r[`CPAC_PUMP_OFS_SNK_BIT];
    assign highCurrentPumpSelect = pumpReg_r[`CPAC_PUMP_HIGH_BIT];

    // The analog trim sees the currents in microamps, one cycle after the field outputs change.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sinkCurrentUa <= 12'h000;
            sourceCurrentUa <= 12'h000;
            offsetCurrentUa <= 12'h000;
        end else begin
            sinkCurrentUa <= codeToUa(pumpSinkCurrentCode, `CPAC_MAIN_STEP_UA);
            sourceCurrentUa <= codeToUa(pumpSourceCurrentCode, `CPAC_MAIN_STEP_UA);
            offsetCurrentUa <= codeToUa(pumpOffsetCurrentCode, `CPAC_OFFSET_STEP_UA);
        end
    end

    assign tuneMeasureLength = calReg_r[`CPAC_CAL_LEN_MSB:`CPAC_CAL_LEN_LSB];
    assign forceStoredCaps = calReg_r[`CPAC_CAL_FORCE_BIT];
    assign calibrationBypass = calReg_r[`CPAC_CAL_BYPASS_BIT];
    assign oscillatorLinkBlock = calReg_r[`CPAC_CAL_BLOCK_BIT];
    assign auxClkSelect = calReg_r[`CPAC_CAL_CLKSEL_MSB:`CPAC_CAL_CLKSEL_LSB];

    // Calibration and the oscillator link share one divided tick.
    cpac_aux_div uAuxDiv (
        .ref_clk(ref_clk),
        .rst(rst),
        .divSel(auxClkSelect),
        .auxTick(auxTick)
    );

    // The measurement spans 1 up to 128 reference divider pulses.
    assign measTarget = 9'h001 << tuneMeasureLength;
    // A new request is only taken while the state machine is idle.
    assign calBusy = (calState_r != CAL_IDLE);

    // The state machine leaves idle at once on a request without bypass and otherwise advances only on
    // calibration clock ticks; reference divider pulses are counted on every edge so none is missed.
    always @* begin
        calState_nxt = calState_r;
        measCnt_nxt = measCnt_r;
        case (calState_r)
            CAL_IDLE: begin
                measCnt_nxt = 9'h000;
                if (calRequest && !calibrationBypass) begin
                    calState_nxt = CAL_SYNC;
                end
            end
            CAL_SYNC: begin
                if (auxTick) begin
                    calState_nxt = CAL_MEASURE;
                end
            end
            CAL_MEASURE: begin
                if (refDivTick && measCnt_r < measTarget) begin
                    measCnt_nxt = measCnt_r + 9'h001;
                end
                if (auxTick && measCnt_r >= measTarget) begin
                    calState_nxt = CAL_FINISH;
                end
            end
            CAL_FINISH: begin
                if (auxTick) begin
                    calState_nxt = CAL_IDLE;
                end
            end
            default: begin
                calState_nxt = CAL_IDLE;
            end
        endcase
    end

    // The done pulse lasts one cycle, for a bypassed and a measured request alike.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            calState_r <= CAL_IDLE;
            measCnt_r <= 9'h000;
            calCaps_r <= {CAPS_W{1'b0}};
            calDone <= 1'b0;
        end else begin
            calState_r <= calState_nxt;
            measCnt_r <= measCnt_nxt;
            calDone <= 1'b0;
            if (calState_r == CAL_IDLE && calRequest && calibrationBypass) begin
                calDone <= 1'b1;
            end
            if (calState_r == CAL_FINISH && auxTick) begin
                calCaps_r <= measuredCaps;
                calDone <= 1'b1;
            end
        end
    end

    // A forced selection follows storedCaps every cycle, so a new stored
    // setting reaches the oscillator one cycle after it appears.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            capSelect <= {CAPS_W{1'b0}};
        end else if (forceStoredCaps) begin
            capSelect <= storedCaps;
        end else begin
            capSelect <= calCaps_r;
        end
    end

    // A write to the oscillator access register starts a transfer unless
    // blocked; a write arriving during a transfer is dropped.
    assign linkStart = oscRegWrite && !oscillatorLinkBlock && !linkActive_r;
    assign linkBusy = linkActive_r;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            linkActive_r <= 1'b0;
            linkShift_r <= {LINK_W{1'b0}};
            linkBits_r <= 8'h00;
            linkClk <= 1'b0;
            linkData <= 1'b0;
            linkFrame <= 1'b0;
        end else if (linkStart) begin
            linkActive_r <= 1'b1;
            linkShift_r <= oscRegData;
            linkBits_r <= LINK_W[7:0];
            linkClk <= 1'b0;
            linkData <= oscRegData[LINK_W-1];
            linkFrame <= 1'b1;
        end else if (linkActive_r && auxTick) begin
            if (!linkClk) begin
                linkClk <= 1'b1;
            end else begin
                linkClk <= 1'b0;
                linkShift_r <= {linkShift_r[LINK_W-2:0], 1'b0};
                linkData <= linkShift_r[LINK_W-2];
                linkBits_r <= linkBits_r - 8'h01;
                // The last falling edge ends the frame and parks the data line low.
                if (linkBits_r == 8'h01) begin
                    linkActive_r <= 1'b0;
                    linkFrame <= 1'b0;
                    linkData <= 1'b0;
                end
            end
        end
    end

endmodule // cpac_config_regs

/* File: rtl/cpac_map.vh */
`ifndef CPAC_MAP_VH
`define CPAC_MAP_VH

// Register indices on the configuration port.
`define CPAC_ADDR_PUMP 6'h09
`define CPAC_ADDR_CAL 6'h0A

// Reset values.
`define CPAC_RST_PUMP 24'h403264
`define CPAC_RST_CAL 24'h002205

// Charge pump register fields.
`define CPAC_PUMP_SINK_LSB 0
`define CPAC_PUMP_SINK_MSB 6
`define CPAC_PUMP_SOURCE_LSB 7
`define CPAC_PUMP_SOURCE_MSB 13
`define CPAC_PUMP_OFFSET_LSB 14
`define CPAC_PUMP_OFFSET_MSB 20
`define CPAC_PUMP_OFS_SRC_BIT 21
`define CPAC_PUMP_OFS_SNK_BIT 22
`define CPAC_PUMP_HIGH_BIT 23

// Calibration register fields.
`define CPAC_CAL_LEN_LSB 0
`define CPAC_CAL_LEN_MSB 2
`define CPAC_CAL_RSVD_LSB 3
`define CPAC_CAL_RSVD_MSB 9
`define CPAC_CAL_FORCE_BIT 10
`define CPAC_CAL_BYPASS_BIT 11
`define CPAC_CAL_BLOCK_BIT 12
`define CPAC_CAL_CLKSEL_LSB 13
`define CPAC_CAL_CLKSEL_MSB 14

// Current steps in microamps.
`define CPAC_MAIN_STEP_UA 12'h014
`define CPAC_OFFSET_STEP_UA 12'h005

// Calibration clock division ratios minus one, per select code.
`define CPAC_DIV0_TERM 5'h00
`define CPAC_DIV1_TERM 5'h03
`define CPAC_DIV2_TERM 5'h0F
`define CPAC_DIV3_TERM 5'h1F

`endif

/* File: testbench/cpac_config_checker.sv */
`timescale 1ns/10ps
module cpac_config_checker #(parameter LINK_W = 16) (
    input wire ref_clk,
    input wire rst,
    input wire wrEn,
    input wire [5:0] wrAddr,
    input wire [23:0] wrData,
    input wire rdEn,
    input wire [5:0] rdAddr,
    input wire [23:0] rdData,
    input wire rdValid,
    input wire [6:0] pumpSinkCurrentCode,
    input wire [6:0] pumpSourceCurrentCode,
    input wire [6:0] pumpOffsetCurrentCode,
    input wire offsetSourceEnable,
    input wire offsetSinkEnable,
    input wire highCurrentPumpSelect,
    input wire [11:0] sinkCurrentUa,
    input wire [2:0] tuneMeasureLength,
    input wire forceStoredCaps,
    input wire calibrationBypass,
    input wire oscillatorLinkBlock,
    input wire [1:0] auxClkSelect,
    input wire calRequest,
    input wire [7:0] storedCaps,
    input wire [7:0] capSelect,
    input wire calBusy,
    input wire calDone,
    input wire oscRegWrite,
    input wire [LINK_W-1:0] oscRegData,
    input wire linkData,
    input wire linkFrame,
    input wire linkBusy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    rd_answer_a:
        assert property (rdEn |=> rdValid) else $error("read not answered");
    rd_unmapped_a:
        assert property (rdEn && rdAddr != 6'h09 && rdAddr != 6'h0A |=> rdData == 24'h000000)
        else $error("unmapped read not zero");
    pump_write_a:
        assert property (wrEn && wrAddr == 6'h09 |=> {highCurrentPumpSelect, offsetSinkEnable,
        offsetSourceEnable, pumpOffsetCurrentCode, pumpSourceCurrentCode, pumpSinkCurrentCode} == $past(wrData))
        else $error("pump fields wrong");
    cal_write_a:
        assert property (wrEn && wrAddr == 6'h0A |=> {auxClkSelect, oscillatorLinkBlock, calibrationBypass,
        forceStoredCaps, tuneMeasureLength} == {$past(wrData[14:10]), $past(wrData[2:0])})
        else $error("calibration fields wrong");
    sink_ua_a:
        assert property (1'b1 |=> sinkCurrentUa == $past(pumpSinkCurrentCode) * 12'h014)
        else $error("sink current wrong");
    bypass_done_a:
        assert property (calRequest && !calBusy && calibrationBypass |=> calDone && $stable(capSelect))
        else $error("bypass not immediate");
    force_caps_a:
        assert property (forceStoredCaps |=> capSelect == $past(storedCaps)) else $error("caps not forced");
    link_start_a:
        assert property (oscRegWrite && !linkBusy |=> linkFrame == !$past(oscillatorLinkBlock))
        else $error("link start wrong");
endmodule // cpac_config_checker

bind cpac_config_regs cpac_config_checker #(.LINK_W(LINK_W)) cpac_config_checker_i (
    .ref_clk(ref_clk), .rst(rst), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn), .rdAddr(rdAddr),
    .rdData(rdData), .rdValid(rdValid), .pumpSinkCurrentCode(pumpSinkCurrentCode),
    .pumpSourceCurrentCode(pumpSourceCurrentCode), .pumpOffsetCurrentCode(pumpOffsetCurrentCode),
    .offsetSourceEnable(offsetSourceEnable), .offsetSinkEnable(offsetSinkEnable),
    .highCurrentPumpSelect(highCurrentPumpSelect), .sinkCurrentUa(sinkCurrentUa),
    .tuneMeasureLength(tuneMeasureLength), .forceStoredCaps(forceStoredCaps), .calibrationBypass(calibrationBypass),
    .oscillatorLinkBlock(oscillatorLinkBlock), .auxClkSelect(auxClkSelect), .calRequest(calRequest),
    .storedCaps(storedCaps), .capSelect(capSelect), .calBusy(calBusy), .calDone(calDone),
    .oscRegWrite(oscRegWrite), .oscRegData(oscRegData), .linkData(linkData), .linkFrame(linkFrame),
    .linkBusy(linkBusy)
);

/* File: testbench/cpac_host_model.sv */
`timescale 1ns/10ps
module cpac_host_model (
    input wire ref_clk,
    input wire [23:0] rdData,
    input wire rdValid,
    output logic wrEn = 0,
    output logic [5:0] wrAddr = 0,
    output logic [23:0] wrData = 0,
    output logic rdEn = 0,
    output logic [5:0] rdAddr = 0,
    output logic refDivTick = 0
);
    always @(posedge ref_clk) begin
        #1 refDivTick = $urandom % 2;
    end
    task wr(input [5:0] a, input [23:0] d);
        @(posedge ref_clk) #1;
        wrEn = 1;
        wrAddr = a;
        wrData = d;
        @(posedge ref_clk) #1;
        wrEn = 0;
        wrData = ~d;
    endtask
    task rd(input [5:0] a, output [24:0] d);
        @(posedge ref_clk) #1;
        rdEn = 1;
        rdAddr = a;
        @(posedge ref_clk) #1;
        rdEn = 0;
        d = {rdValid, rdData};
    endtask
endmodule // cpac_host_model

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic ref_clk = 0, rst = 1, calRequest = 0, oscRegWrite = 0;
    logic [7:0] measuredCaps = 0, storedCaps = 0, capOld;
    logic [15:0] oscRegData = 0, got;
    logic [24:0] r;
    logic prevClk, busySeen;
    wire wrEn, rdEn, rdValid, refDivTick, forceStoredCaps, calibrationBypass, oscillatorLinkBlock;
    wire offsetSourceEnable, offsetSinkEnable, highCurrentPumpSelect, calBusy, calDone;
    wire linkClk, linkData, linkFrame, linkBusy;
    wire [5:0] wrAddr, rdAddr;
    wire [23:0] wrData, rdData;
    wire [6:0] pumpSinkCurrentCode, pumpSourceCurrentCode, pumpOffsetCurrentCode;
    wire [11:0] sinkCurrentUa, sourceCurrentUa, offsetCurrentUa;
    wire [2:0] tuneMeasureLength;
    wire [1:0] auxClkSelect;
    wire [7:0] capSelect;
    int pumpM = 'h403264, calM = 'h002205, nErrors = 0, compares = 0, n;
    cpac_config_regs cpac_config_regs_i (
        .ref_clk(ref_clk), .rst(rst), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn),
        .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid), .pumpSinkCurrentCode(pumpSinkCurrentCode),
        .pumpSourceCurrentCode(pumpSourceCurrentCode), .pumpOffsetCurrentCode(pumpOffsetCurrentCode),
        .offsetSourceEnable(offsetSourceEnable), .offsetSinkEnable(offsetSinkEnable),
        .highCurrentPumpSelect(highCurrentPumpSelect), .sinkCurrentUa(sinkCurrentUa),
        .sourceCurrentUa(sourceCurrentUa), .offsetCurrentUa(offsetCurrentUa),
        .tuneMeasureLength(tuneMeasureLength), .forceStoredCaps(forceStoredCaps),
        .calibrationBypass(calibrationBypass), .oscillatorLinkBlock(oscillatorLinkBlock),
        .auxClkSelect(auxClkSelect), .calRequest(calRequest), .refDivTick(refDivTick),
        .measuredCaps(measuredCaps), .storedCaps(storedCaps), .capSelect(capSelect), .calBusy(calBusy),
        .calDone(calDone), .oscRegWrite(oscRegWrite), .oscRegData(oscRegData), .linkClk(linkClk),
        .linkData(linkData), .linkFrame(linkFrame), .linkBusy(linkBusy)
    );
    cpac_host_model cpac_host_model_i (
        .ref_clk(ref_clk), .rdData(rdData), .rdValid(rdValid), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
        .rdEn(rdEn), .rdAddr(rdAddr), .refDivTick(refDivTick)
    );
    initial forever #50 ref_clk = ~ref_clk;
    task chk(input [31:0] g, input [31:0] e);
        compares++;
        if (g !== e) begin
            nErrors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task complete_run;
        if (nErrors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chkAll(input [5:0] a);
        cpac_host_model_i.rd(a, r);
        chk(r, {1'b1, a == 6'h09 ? pumpM[23:0] : a == 6'h0A ? calM[23:0] : 24'h000000});
        chk({highCurrentPumpSelect, offsetSinkEnable, offsetSourceEnable, pumpOffsetCurrentCode,
            pumpSourceCurrentCode, pumpSinkCurrentCode}, pumpM);
        chk({auxClkSelect, oscillatorLinkBlock, calibrationBypass, forceStoredCaps, tuneMeasureLength},
            {calM[14:10], calM[2:0]});
        chk({sinkCurrentUa, sourceCurrentUa}, pumpM[6:0] * 20 * 4096 + pumpM[13:7] * 20);
        chk(offsetCurrentUa, pumpM[20:14] * 5);
    endtask
    task access(input [5:0] a, input [23:0] d);
        cpac_host_model_i.wr(a, d);
        if (a == 6'h09) pumpM = d;
        else if (a == 6'h0A) calM = d;
        chkAll(a);
    endtask
    task pulse(input bit cal);
        @(posedge ref_clk) #1;
        if (cal) calRequest = 1;
        else oscRegWrite = 1;
        @(posedge ref_clk) #1;
        calRequest = 0;
        oscRegWrite = 0;
        n = 1;
        got = 0;
        prevClk = 0;
        busySeen = cal ? calBusy : linkBusy;
        while ((cal ? calDone !== 1 : n < 300) && n < 2000) begin
            if (!cal && linkClk === 1 && prevClk !== 1 && linkFrame === 1) got = {got[14:0], linkData};
            prevClk = linkClk;
            @(posedge ref_clk) #1;
            n++;
        end
    endtask
    initial begin
        void'($urandom(11951));
        repeat (3) @(posedge ref_clk);
        #1 rst = 0;
        chkAll(6'h09);
        chkAll(6'h0A);
        for (int i = 0; i < 30; i++) access(i % 3 == 2 ? $urandom : 6'h09 + i % 2, $urandom);
        for (int s = 0; s < 4; s++) begin
            access(6'h0A, 24'h000040 + s * 'h2001);
            measuredCaps = $urandom;
            pulse(1);
            chk(n > (s == 0 ? 1 : 4 ** s - (s == 3 ? 32 : 0)) && n < 2000, 1);
            repeat (2) @(posedge ref_clk);
            chk(capSelect, measuredCaps);
            chk({busySeen, calBusy}, 2'b10);
        end
        capOld = measuredCaps;
        access(6'h0A, 24'h000840);
        measuredCaps = ~capOld;
        pulse(1);
        chk({n[15:0], capSelect, busySeen}, {16'd1, capOld, 1'b0});
        storedCaps = $urandom;
        access(6'h0A, 24'h000440);
        chk(capSelect, storedCaps);
        for (int s = 0; s < 2; s++) begin
            access(6'h0A, 24'h000040 + s * 'h2000);
            oscRegData = $urandom;
            pulse(0);
            chk({got, linkFrame, linkBusy, busySeen}, {oscRegData, 3'b001});
        end
        access(6'h0A, 24'h001040);
        pulse(0);
        chk({got, busySeen}, 0);
        access(6'h09, 24'h403264);
        access(6'h0A, 24'h002047);
        complete_run;
    end
    initial begin
        #1000000;
        nErrors++;
        complete_run;
    end
endmodule // testbench
